// ==== pkg/spb_pkg.sv ====
// Purpose: Shared constants, types and group mapping for the sector protection block.
// Assumes: 40 MHz clock, 32-bit classic Wishbone, 25-bit array byte addresses.
// Notes: Register offsets are byte addresses on the Wishbone port.
package spb_pkg;
   // Register byte offsets.
   localparam logic [3:0] SPB_REG_CMD = 4'h0;
   localparam logic [3:0] SPB_REG_ADDR = 4'h4;
   localparam logic [3:0] SPB_REG_STATUS = 4'h8;
   localparam logic [3:0] SPB_REG_RESULT = 4'hc;
   // Field positions inside the command word.
   localparam int SPB_CMD_OP_LSB = 0;
   localparam int SPB_CMD_VAL_BIT = 8;
   // Geometry of the protection groups.
   localparam int SPB_ADDR_W = 25;
   localparam int SPB_GRP_W = 10;
   localparam int SPB_GROUPS = 542;
   localparam logic [8:0] SPB_UNIFORM_BLOCKS = 9'h1fe;
   localparam logic [8:0] SPB_BOTTOM_BLOCKS = 9'h002;
   localparam logic [9:0] SPB_TOP_FIRST_GRP = 10'h1fe;
   localparam logic [9:0] SPB_BOTTOM_OFFSET = 10'h01e;
   // Reset values.
   localparam logic SPB_DYN_RESET = 1'b1;
   localparam logic SPB_PERS_ERASED = 1'b1;
   // Timing.
   localparam int SPB_CLK_MHZ = 40;
   localparam int SPB_ACCESS_NS = 100;
   localparam int SPB_ACCESS_CYC = (SPB_ACCESS_NS * SPB_CLK_MHZ + 999) / 1000;
   localparam int SPB_VERIFY_CYC = 1;

   typedef enum logic [2:0] {
      SPB_OP_NONE = 3'h0,
      SPB_OP_PERS_PROG = 3'h1,
      SPB_OP_PERS_ERASE = 3'h2,
      SPB_OP_PERS_READ = 3'h3,
      SPB_OP_DYN_WRITE = 3'h4,
      SPB_OP_DYN_READ = 3'h5,
      SPB_OP_LOCK_CLEAR = 3'h6,
      SPB_OP_SPARE = 3'h7
   } spb_op_t;

   typedef enum logic [5:0] {
      SPB_ST_IDLE = 6'h01,
      SPB_ST_PROG = 6'h02,
      SPB_ST_PRE = 6'h04,
      SPB_ST_VERIFY = 6'h08,
      SPB_ST_ERASE = 6'h10,
      SPB_ST_READ = 6'h20
   } spb_state_t;

   typedef struct packed {
      logic dyn_val;
      spb_op_t op;
   } spb_cmd_t;

   typedef struct packed {
      logic pwd_mode;
      logic array_hold;
      logic fail;
      logic guard_lock;
      logic wip;
   } spb_status_t;

   typedef struct packed {
      logic valid;
      logic protected_grp;
      logic dyn_bit;
      logic pers_bit;
   } spb_result_t;

   // Address to group index; top placement puts the 4 KB sectors in the last two blocks.
   function automatic logic [9:0] spb_group_of(input logic [24:0] a, input logic top);
      logic [8:0] blk;
      blk = a[24:16];
      if (top) begin
         if (blk < SPB_UNIFORM_BLOCKS) spb_group_of = {1'b0, blk};
         else spb_group_of = SPB_TOP_FIRST_GRP + {5'h00, a[16:12]};
      end else begin
         if (blk < SPB_BOTTOM_BLOCKS) spb_group_of = {5'h00, a[16:12]};
         else spb_group_of = {1'b0, blk} + SPB_BOTTOM_OFFSET;
      end
   endfunction
endpackage

// ==== logic/spb_top.sv ====
// Purpose: Persistent and dynamic per-group write protection with a guard lock.
// Assumes: Synchronous active-high reset stands for power-up and hardware reset.
// Notes: Password comparison lives outside; only its success pulse arrives here.
`timescale 1ns/1ps
// Function
// R1: One persistent bit kept per protection group.
// R2: Program singly to 0, erase all to 1.
// R3: Erase takes no address, acts on all.
// R4: Device preprograms and verifies before erasing.
// R5: Program takes page time, erase sector time.
// R6: Busy status shown during program or erase.
// R7: No array reads while persistent bit programs.
// R8: Host reads at group start, high bits zero.
// R9: Dedicated read returns addressed persistent bit.
// R10: Persistent read waits initial access latency.
// R11: Persistent bits delivered erased to 1.
// R12: One volatile dynamic bit per group.
// R13: Dynamic write clears or sets addressed bit.
// R14: Programmed persistent bit overrides dynamic bit.
// R15: Lock at 0 refuses persistent changes.
// R16: Persistent mode: lock set at reset.
// R17: Persistent mode: software never sets lock.
// R18: Password mode: lock cleared at reset.
// R19: Password mode: only unlock sets lock.
// R20: Host clears lock after configuring bits.
// R21: Group protected when either bit is 0.
// R22: Dynamic bits reset to 1.
// R23: Lock-clear command clears the lock.
// R24: 542 groups: 510 blocks, 32 sectors.
// R25: Top placement maps blocks then top sectors.
module spb_top
   import spb_pkg::*;
#(
   parameter int PROG_US = 400,
   parameter int ERASE_US = 50000,
   parameter int N_GROUPS = 542
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic password_mode_i,
   input wire logic pwd_unlock_ok_i,
   input wire logic param_sector_placement_i,
   input wire logic [24:0] chk_addr_i,
   output logic chk_protected_o,
   output logic array_read_hold_o,
   output logic busy_o
);
   // Cycle counts; these are typical times so they are not rounded.
   localparam int PROG_CYC = PROG_US * SPB_CLK_MHZ;
   localparam int ERASE_CYC = ERASE_US * SPB_CLK_MHZ;

   // The mapping function serves exactly the documented geometry.
   if (N_GROUPS != SPB_GROUPS || PROG_CYC < 1 || ERASE_CYC < 1) begin : g_chk
      $error("spb_top: unsupported group count or zero timing");
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Non-volatile bits: no reset, delivered erased.
   logic [N_GROUPS-1:0] pers = {N_GROUPS{SPB_PERS_ERASED}}; // R1 R11
   logic [N_GROUPS-1:0] dyn;
   logic guard_lock;
   logic fail;
   spb_state_t state;
   spb_state_t next_state;
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic [24:0] addr;
   logic [9:0] tgt;
   spb_result_t result;

   // Bus decode.
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr_req = wb_req & wb_we_i;
   wire rd_req = wb_req & ~wb_we_i;
   wire cmd_wr = wr_req & (wb_adr_i == SPB_REG_CMD) & wb_sel_i[0];
   wire addr_wr = wr_req & (wb_adr_i == SPB_REG_ADDR);
   wire spb_cmd_t cmd = {wb_dat_i[SPB_CMD_VAL_BIT], wb_dat_i[SPB_CMD_OP_LSB +: 3]};
   wire idle = state == SPB_ST_IDLE;
   wire op_ok = cmd_wr & idle;
   // The command word carries no address; the group comes from the address register.
   wire [9:0] cmd_grp = spb_group_of(addr, param_sector_placement_i); // R25 R24
   wire [9:0] chk_grp = spb_group_of(chk_addr_i, param_sector_placement_i);
   wire go_prog = op_ok & (cmd.op == SPB_OP_PERS_PROG) & guard_lock; // R15
   wire go_erase = op_ok & (cmd.op == SPB_OP_PERS_ERASE) & guard_lock; // R15 R3
   wire go_read = op_ok & ((cmd.op == SPB_OP_PERS_READ) | (cmd.op == SPB_OP_DYN_READ)); // R9
   wire refused = op_ok & ~guard_lock
                  & ((cmd.op == SPB_OP_PERS_PROG) | (cmd.op == SPB_OP_PERS_ERASE)); // R15
   wire dyn_wr = op_ok & (cmd.op == SPB_OP_DYN_WRITE);
   wire lock_clr = op_ok & (cmd.op == SPB_OP_LOCK_CLEAR);
   // Only a good password while in password mode reopens the lock.
   wire lock_set = pwd_unlock_ok_i & password_mode_i; // R19 R17
   wire done = cnt == 32'h0;
   wire verify_ok = ~|pers;
   wire unprot_now = pers[chk_grp] & dyn[chk_grp]; // R21 R14

   // Status and result views.
   wire spb_status_t status = {password_mode_i, array_read_hold_o, fail, guard_lock, busy_o}; // R6
   wire [31:0] rd_mux = (wb_adr_i == SPB_REG_CMD) ? 32'h0 :
                        (wb_adr_i == SPB_REG_ADDR) ? {7'h00, addr} :
                        (wb_adr_i == SPB_REG_STATUS) ? {27'h0, status} :
                        (wb_adr_i == SPB_REG_RESULT) ? {28'h0, result} : 32'h0;

   // Sequencer: erase runs preprogram, verify, then the bulk erase.
   always_comb begin
      next_state = state;
      next_cnt = (cnt == 32'h0) ? 32'h0 : cnt - 32'h1;
      case (state)
         SPB_ST_IDLE: begin
            if (go_prog) begin
               next_state = SPB_ST_PROG;
               next_cnt = 32'(PROG_CYC - 1); // R5
            end else if (go_erase) begin
               next_state = SPB_ST_PRE; // R4
               next_cnt = 32'(PROG_CYC - 1);
            end else if (go_read) begin
               next_state = SPB_ST_READ;
               next_cnt = 32'(SPB_ACCESS_CYC - 1); // R10
            end
         end
         SPB_ST_PROG: begin
            if (done) next_state = SPB_ST_IDLE;
         end
         SPB_ST_PRE: begin
            if (done) begin
               next_state = SPB_ST_VERIFY;
               next_cnt = 32'(SPB_VERIFY_CYC - 1);
            end
         end
         SPB_ST_VERIFY: begin
            // A failed verify repeats the preprogram rather than erase a mixed array.
            if (done && verify_ok) begin
               next_state = SPB_ST_ERASE;
               next_cnt = 32'(ERASE_CYC - 1); // R5
            end else if (done) begin
               next_state = SPB_ST_PRE; // R4
               next_cnt = 32'(PROG_CYC - 1);
            end
         end
         SPB_ST_ERASE: begin
            if (done) next_state = SPB_ST_IDLE;
         end
         SPB_ST_READ: begin
            if (done) next_state = SPB_ST_IDLE;
         end
         default: begin
            next_state = SPB_ST_IDLE;
            next_cnt = 32'h0;
         end
      endcase
   end

   // State register and counter.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= SPB_ST_IDLE;
         cnt <= 32'h0;
      end else if (ce_i) begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // Target group is latched at command time so a later address write cannot move it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tgt <= 10'h0;
      end else if (ce_i && op_ok) begin
         tgt <= cmd_grp;
      end
   end

   // Address register with byte lanes.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr <= 25'h0;
      end else if (ce_i && addr_wr) begin
         for (int b = 0; b < 3; b++) begin
            if (wb_sel_i[b]) addr[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
         end
         // The address is 25 bits wide, so only bit 24 of the top lane is kept.
         if (wb_sel_i[3]) addr[24] <= wb_dat_i[24];
      end
   end

   // Persistent bits change only at the end of a program or erase phase; no reset.
   always_ff @(posedge clk_i) begin
      if (ce_i && !rst_i) begin
         if (state == SPB_ST_PROG && done) pers[tgt] <= 1'b0; // R2
         if (state == SPB_ST_PRE && done) pers <= '0; // R4
         if (state == SPB_ST_ERASE && done) pers <= {N_GROUPS{SPB_PERS_ERASED}}; // R2 R3
      end
   end

   // Dynamic bits, freely writable while idle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dyn <= {N_GROUPS{SPB_DYN_RESET}}; // R22
      end else if (ce_i && dyn_wr) begin
         dyn[cmd_grp] <= cmd.dyn_val; // R12 R13
      end
   end

   // Guard lock; reset value depends on the protection mode.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         guard_lock <= ~password_mode_i; // R16 R18
      end else if (ce_i) begin
         if (lock_clr) guard_lock <= 1'b0; // R23
         else if (lock_set) guard_lock <= 1'b1; // R19
      end
   end

   // Failure flag: a refusal wins over the clear from an accepted command.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fail <= 1'b0;
      end else if (ce_i) begin
         if (refused) fail <= 1'b1; // R15
         else if (op_ok) fail <= 1'b0;
      end
   end

   // Read result is captured only after the access latency.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result <= '0;
      end else if (ce_i) begin
         if (go_read) result.valid <= 1'b0;
         else if (state == SPB_ST_READ && done) begin
            result <= {1'b1, ~(pers[tgt] & dyn[tgt]), dyn[tgt], pers[tgt]}; // R9 R10
         end
      end
   end

   // Wishbone answer: ack one cycle after the request, dropped the cycle after.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else if (ce_i) begin
         wb_ack_o <= wb_req;
         wb_dat_o <= rd_req ? rd_mux : 32'h0;
      end
   end

   // Registered outputs toward the array and status logic.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chk_protected_o <= 1'b0;
         array_read_hold_o <= 1'b0;
         busy_o <= 1'b0;
      end else if (ce_i) begin
         chk_protected_o <= ~unprot_now; // R21 R14
         array_read_hold_o <= next_state == SPB_ST_PROG; // R7
         busy_o <= next_state != SPB_ST_IDLE; // R6
      end
   end

   lock_reset_a: assert property ($past(rst_i) |-> guard_lock == ~$past(password_mode_i)) // R16 R18
      else $error("guard lock reset value wrong");
   lock_stays_a: assert property (ce_i && !guard_lock && !password_mode_i |=> !guard_lock) // R17
      else $error("guard lock set by software");
   lock_source_a: assert property ($rose(guard_lock) |-> $past(pwd_unlock_ok_i && password_mode_i)) // R19
      else $error("guard lock set without unlock");
   lock_clear_a: assert property (ce_i && lock_clr |=> !guard_lock) // R23
      else $error("lock clear ignored");
   pers_guard_a: assert property (ce_i && idle && cmd_wr && !guard_lock // R15
                                  && (cmd.op == SPB_OP_PERS_PROG || cmd.op == SPB_OP_PERS_ERASE) |=> idle && fail)
      else $error("locked persistent change started");
   erase_all_a: assert property (state == SPB_ST_ERASE && done && ce_i |=> &pers) // R2
      else $error("erase left a programmed bit");
   erase_pre_a: assert property (ce_i && go_erase |=> state == SPB_ST_PRE) // R4
      else $error("erase skipped preprogram");
   read_lat_a: assert property (ce_i && go_read |-> ##1 (state == SPB_ST_READ)[*4] ##1 result.valid) // R10
      else $error("read latency wrong");
   hold_prog_a: assert property (state == SPB_ST_PROG |-> array_read_hold_o) // R7
      else $error("array reads allowed during program");
   busy_stat_a: assert property (!idle |-> busy_o && status.wip) // R6
      else $error("busy not reported");
   prot_out_a: assert property (ce_i |=> chk_protected_o == $past(!(pers[chk_grp] && dyn[chk_grp]))) // R21
      else $error("protection output wrong");
   dyn_reset_a: assert property ($past(rst_i) |-> &dyn) // R22
      else $error("dynamic bits not reset");
   dyn_write_a: assert property (ce_i && dyn_wr |=> dyn[$past(cmd_grp)] == $past(cmd.dyn_val)) // R13
      else $error("dynamic write lost");
endmodule

// ==== testbench/spb_host.sv ====
// Purpose: Wishbone host model that issues protection commands.
// Assumes: Classic single cycles, one request at a time.
// Notes: An ack missing after 64 cycles is counted in tmo.
`timescale 1ns/1ps
module spb_host (
   input wire logic clk_i,
   input wire logic ack_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [3:0] adr_o,
   output logic [31:0] dat_o
);
   int tmo = 0;
   // Idle levels at time zero.
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 4'h0;
      dat_o = 32'h0;
   end
   // The request stays still until ack is sampled; released data is inverted so no stale value lingers.
   task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      dat_o <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_i !== 1'b1 && n < 64);
      if (ack_i !== 1'b1) tmo++;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      dat_o <= ~d;
   endtask
endmodule

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the sector protection block.
// Assumes: Program and erase times shortened to 1 and 2 microseconds.
// Notes: Read results are queued by the driver and checked by a watcher.
`timescale 1ns/1ps
module testbench import spb_pkg::*;;
   localparam int PROG_C = SPB_CLK_MHZ;
   localparam int ERASE_C = PROG_C + SPB_VERIFY_CYC + 2 * SPB_CLK_MHZ;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic pmode = 1'b0;
   logic unlock = 1'b0;
   logic ce = 1'b1;
   logic [24:0] caddr = 25'h0;
   logic cyc, stb, we, ack, prot, hold, busy;
   logic [3:0] adr;
   logic [31:0] wdat, rdat;
   logic [24:0] sa, ba;
   logic [31:0] exp_q[$];
   int bad_count = 0;
   int compares = 0;

   spb_top #(.PROG_US(1), .ERASE_US(2), .N_GROUPS(SPB_GROUPS)) DUT (
      .clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .password_mode_i(pmode), .pwd_unlock_ok_i(unlock), .param_sector_placement_i(1'b1),
      .chk_addr_i(caddr), .chk_protected_o(prot), .array_read_hold_o(hold), .busy_o(busy));
   spb_host host (.clk_i(clk), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .dat_o(wdat));

   // 40 MHz clock.
   always #12.5 clk = ~clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Every read answer retires the oldest expected note.
   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0) chk(rdat, exp_q.size() > 0 ? exp_q.pop_front() : ~rdat);
   end

   // A bus request that never got its ack ends the run at once.
   always @(posedge clk) begin
      if (host.tmo != 0) end_sim();
   end

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      host.xfer(1'b0, a, 32'h0);
   endtask
   task automatic cmd(input spb_op_t op, input logic v, input logic [24:0] a);
      host.xfer(1'b1, SPB_REG_ADDR, {7'h00, a});
      host.xfer(1'b1, SPB_REG_CMD, {23'h000000, v, 5'h00, op});
   endtask
   // Waits out busy and checks that it lasted about the expected count.
   task automatic idle(input int max);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (busy !== 1'b0 && n < max + 8);
      chk(n >= max - 8 && n <= max + 1, 1'b1);
      if (busy !== 1'b0) end_sim();
   endtask
   task automatic pbit(input spb_op_t op, input logic [24:0] a, input logic [31:0] e);
      cmd(op, 1'b0, a);
      idle(SPB_ACCESS_CYC);
      rd(SPB_REG_RESULT, e);
   endtask
   // The check port answers one cycle after the address.
   task automatic probe(input logic [24:0] a, input logic e);
      @(posedge clk);
      caddr <= a;
      @(posedge clk);
      @(negedge clk);
      chk(prot, e);
   endtask
   task automatic pulse();
      @(posedge clk);
      unlock <= 1'b1;
      @(posedge clk);
      unlock <= 1'b0;
   endtask
   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
   endtask
   task automatic end_sim();
      chk(host.tmo, 0);
      chk(exp_q.size(), 0);
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Watchdog against a hang.
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      end_sim();
   end

   // Main sequence; group addresses are group starts with unused high bits zero.
   initial begin
      void'($urandom(60798));
      sa = {8'hff, 17'($urandom)} & 25'h1fff000;
      ba = {9'($urandom_range(0, 509)), 16'h0000};
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(SPB_REG_STATUS, 32'h02);
      pbit(SPB_OP_PERS_READ, ba, 32'hb);
      cmd(SPB_OP_DYN_WRITE, 1'b0, sa);
      pbit(SPB_OP_DYN_READ, sa, 32'hd);
      probe(sa | 25'($urandom_range(0, 4095)), 1'b1);
      probe(sa ^ 25'h1000, 1'b0);
      probe(ba + 25'hfff0, 1'b0);
      cmd(SPB_OP_PERS_PROG, 1'b0, ba);
      rd(SPB_REG_STATUS, 32'h0b);
      chk(hold, 1'b1);
      idle(PROG_C);
      pbit(SPB_OP_PERS_READ, ba, 32'he);
      probe(ba + 25'h1234, 1'b1);
      cmd(SPB_OP_DYN_WRITE, 1'b1, sa);
      probe(sa, 1'b0);
      cmd(SPB_OP_PERS_ERASE, 1'b0, 25'($urandom));
      idle(ERASE_C);
      pbit(SPB_OP_PERS_READ, ba, 32'hb);
      cmd(SPB_OP_LOCK_CLEAR, 1'b0, ba);
      pulse();
      cmd(SPB_OP_PERS_PROG, 1'b0, ba);
      rd(SPB_REG_STATUS, 32'h04);
      pbit(SPB_OP_PERS_READ, ba, 32'hb);
      rd(4'h2, 32'h0);
      rd(SPB_REG_CMD, 32'h0);
      pmode <= 1'b1;
      do_reset();
      rd(SPB_REG_STATUS, 32'h10);
      pbit(SPB_OP_DYN_READ, sa, 32'hb);
      pulse();
      rd(SPB_REG_STATUS, 32'h12);
      cmd(SPB_OP_PERS_PROG, 1'b0, sa);
      // Ten edges with the clock enable low must stretch the program by as many cycles.
      @(posedge clk);
      ce <= 1'b0;
      repeat (10) @(posedge clk);
      chk(busy, 1'b1);
      ce <= 1'b1;
      idle(PROG_C);
      pbit(SPB_OP_PERS_READ, sa, 32'he);
      pmode <= 1'b0;
      do_reset();
      rd(SPB_REG_STATUS, 32'h02);
      probe(sa + 25'h0ff0, 1'b1);
      end_sim();
   end
endmodule
